// [sfe_pkg.sv]
// Shared constants and types for the serial flash erase sequencer
package sfe_pkg;

    // Opcodes seen on the serial data input
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_SECREG_PROG = 8'h42;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE = 8'hAB;

    // Frame bit counts
    localparam int BITCNT_W = 12;
    localparam logic [11:0] OP_BITS = 12'h008;
    localparam logic [11:0] ADDR_END = 12'h020;
    localparam logic [11:0] DATA_START = 12'h028;
    localparam logic [11:0] BITCNT_MAX = 12'hFFF;

    // Array geometry
    localparam int ADDR_W = 24;
    localparam int SECT_SHIFT = 12;
    localparam int BLK32_SHIFT = 15;
    localparam int BLK64_SHIFT = 16;
    localparam int NUM_BLK64 = 256;
    localparam logic [12:0] NUM_SECT = 13'h1000;
    localparam logic [12:0] SECT_PER_BLK64 = 13'h0010;
    localparam logic [2:0] BP_ALL = 3'h6;

    // Status byte layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam int STAT_SUS_BIT = 7;

    // Reset values
    localparam logic WEL_RST = 1'b0;
    localparam logic PD_RST = 1'b0;

    // Times as printed or chosen, then cycle counts at 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_SE_NS = 100000;
    localparam int T_BE32_NS = 200000;
    localparam int T_BE64_NS = 400000;
    localparam int T_CE_NS = 1000000;
    localparam int T_PP_NS = 50000;
    localparam int T_SUS_NS = 2000;
    localparam int T_DP_NS = 3000;
    localparam int T_RES_NS = 200;

    // All times round down, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CYC_SE = ns_to_cyc(T_SE_NS);
    localparam int CYC_BE32 = ns_to_cyc(T_BE32_NS);
    localparam int CYC_BE64 = ns_to_cyc(T_BE64_NS);
    localparam int CYC_CE = ns_to_cyc(T_CE_NS);
    localparam int CYC_PP = ns_to_cyc(T_PP_NS);
    localparam int CYC_SUS = ns_to_cyc(T_SUS_NS);
    localparam int CYC_DP = ns_to_cyc(T_DP_NS);
    localparam int CYC_RES = ns_to_cyc(T_RES_NS);

    typedef enum logic [2:0] {
        K_SECTOR,
        K_BLK32,
        K_BLK64,
        K_CHIP,
        K_PAGE
    } sfe_kind_e;

    typedef enum {
        ST_IDLE,
        ST_RUN,
        ST_SUSP_WAIT,
        ST_SUSP
    } sfe_state_e;

endpackage

// [sfe_tmr_if.sv]
// Handshake between the sequencer and its self-timed operation counter
`timescale 1ns/100ps
`default_nettype none
interface sfe_tmr_if;
    logic load;
    logic [31:0] load_val;
    logic run;
    logic done;
    modport ctrl (output load, output load_val, output run, input done);
    modport timer (input load, input load_val, input run, output done);
endinterface
`default_nettype wire

// [sfe_op_timer.sv]
// Pausable countdown that times erase and program cycles
`timescale 1ns/100ps
`default_nettype none
module sfe_op_timer (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    sfe_tmr_if.timer tmr
);
    logic [31:0] cnt_q;

    // Count only while running, so a suspend simply holds the remainder
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (tmr.load) begin
                cnt_q <= tmr.load_val;
            end else if (tmr.run && cnt_q != 32'h0000_0000) begin
                cnt_q <= cnt_q - 32'h0000_0001;
            end
        end
    end

    // Last counted cycle ends the operation
    assign tmr.done = tmr.run && clk_en_i && (cnt_q == 32'h0000_0001);
endmodule
`default_nettype wire

// [sfe_flash_seq.sv]
// Serial flash command sequencer: erase, suspend/resume, power-down
`timescale 1ns/100ps
`default_nettype none
module sfe_flash_seq
    import sfe_pkg::*;
#(
    parameter int unsigned SE_CYC = CYC_SE,
    parameter int unsigned BE32_CYC = CYC_BE32,
    parameter int unsigned BE64_CYC = CYC_BE64,
    parameter int unsigned CE_CYC = CYC_CE,
    parameter int unsigned PP_CYC = CYC_PP,
    parameter int unsigned SUS_CYC = CYC_SUS,
    parameter int unsigned DP_CYC = CYC_DP
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic protect_complement_bit_i,
    input wire logic protect_granularity_bit_i,
    input wire logic protect_top_bottom_bit_i,
    input wire logic protect_range_bit2_i,
    input wire logic protect_range_bit1_i,
    input wire logic protect_range_bit0_i,
    input wire logic [NUM_BLK64-1:0] block_lock_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic busy_o,
    output logic write_latch_flag_o,
    output logic suspend_flag_o,
    output logic power_down_o,
    output logic [2:0] op_kind_o,
    output logic [ADDR_W-1:0] op_addr_o,
    output logic op_done_o
);
    localparam int sus_bound_c = SUS_CYC + 1;
    localparam int res_bound_c = CYC_RES;
    localparam int dp_bound_c = DP_CYC + 1;

    logic [2:0] cs_s, ck_s, di_s;
    logic cs_f, ck_f, di_f;
    logic ck_rise, ck_fall, cs_rise, di_bit;
    logic [BITCNT_W-1:0] bitcnt_q;
    logic [31:0] shift_q;
    logic [7:0] op_q, op_next;
    logic [ADDR_W-1:0] addr_q, region;
    sfe_state_e state_q, state_d;
    sfe_kind_e kind_q, new_kind;
    logic wel_q, pd_q, pd_pend_q;
    logic [31:0] sus_cnt_q, dp_cnt_q;
    logic rd_act_q;
    logic [7:0] stat_sh_q;
    logic [2:0] bp;
    logic is8, is32, pp_end, live, region_prot;
    logic erase_cmd, prog_cmd;
    logic acc_erase, acc_prog, acc_susp, acc_res, acc_pd, acc_rel;
    logic wren, wrdi;

    sfe_tmr_if tmr_if ();

    sfe_op_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .tmr(tmr_if.timer)
    );

    // One protected 4K sector per call; ranges grow from top or bottom
    function automatic logic sect_prot(input logic [11:0] sec);
        logic [12:0] n;
        logic hit;
        n = 13'h0000;
        if (bp == 3'h0) begin
            n = 13'h0000;
        end else if (protect_granularity_bit_i) begin
            n = bp[2] ? 13'h0008 : (13'h0001 << (bp[1:0] - 2'h1));
        end else if (bp >= BP_ALL) begin
            n = NUM_SECT;
        end else begin
            n = 13'h0040 << (bp - 3'h1);
        end
        if (protect_top_bottom_bit_i) begin
            hit = {1'b0, sec} < n;
        end else begin
            hit = {1'b0, sec} >= (NUM_SECT - n);
        end
        return hit ^ protect_complement_bit_i;
    endfunction

    // Sector count covered by one operation kind
    function automatic logic [12:0] kind_sects(input sfe_kind_e k);
        case (k)
            K_BLK32: kind_sects = SECT_PER_BLK64 >> 1;
            K_BLK64: kind_sects = SECT_PER_BLK64;
            K_CHIP: kind_sects = NUM_SECT;
            default: kind_sects = 13'h0001;
        endcase
    endfunction

    // Self-timed duration for each operation kind
    function automatic logic [31:0] kind_cyc(input sfe_kind_e k);
        case (k)
            K_SECTOR: kind_cyc = 32'(SE_CYC);
            K_BLK32: kind_cyc = 32'(BE32_CYC);
            K_BLK64: kind_cyc = 32'(BE64_CYC);
            K_CHIP: kind_cyc = 32'(CE_CYC);
            default: kind_cyc = 32'(PP_CYC);
        endcase
    endfunction

    assign bp = {protect_range_bit2_i, protect_range_bit1_i,
                 protect_range_bit0_i};

    // Three-stage pin sampling; a level counts once stages two and
    // three agree, which rejects single-sample glitches
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_s <= 3'h7;
            ck_s <= 3'h0;
            di_s <= 3'h0;
        end else if (clk_en_i) begin
            cs_s <= {cs_s[1:0], cs_n_i};
            ck_s <= {ck_s[1:0], sclk_i};
            di_s <= {di_s[1:0], mosi_i};
        end
    end

    // Filtered levels
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_f <= 1'b1;
            ck_f <= 1'b0;
            di_f <= 1'b0;
        end else if (clk_en_i) begin
            if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
            if (ck_s[1] == ck_s[2]) ck_f <= ck_s[2];
            if (di_s[1] == di_s[2]) di_f <= di_s[2];
        end
    end

    // Edges of the filtered serial clock and chip select
    assign ck_rise = clk_en_i && !cs_f && (ck_s[1] == ck_s[2]) &&
                     ck_s[2] && !ck_f;
    assign ck_fall = clk_en_i && !cs_f && (ck_s[1] == ck_s[2]) &&
                     !ck_s[2] && ck_f;
    assign cs_rise = clk_en_i && (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_f;
    assign di_bit = (di_s[1] == di_s[2]) ? di_s[2] : di_f;
    assign op_next = (bitcnt_q == OP_BITS - 12'h001) ?
                     {shift_q[6:0], di_bit} : op_q;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bitcnt_q <= 12'h000;
            shift_q <= 32'h0000_0000;
            op_q <= 8'h00;
            addr_q <= 24'h00_0000;
        end else if (clk_en_i) begin
            if (cs_f) begin
                bitcnt_q <= 12'h000;
            end else if (ck_rise) begin
                if (bitcnt_q != BITCNT_MAX) bitcnt_q <= bitcnt_q + 12'h001;
                shift_q <= {shift_q[30:0], di_bit};
                op_q <= op_next;
                if (bitcnt_q == ADDR_END - 12'h001) begin
                    addr_q <= {shift_q[22:0], di_bit};
                end
            end
        end
    end

    // Frame length checks at chip select release
    assign is8 = (bitcnt_q == OP_BITS);
    assign is32 = (bitcnt_q == ADDR_END);
    assign pp_end = (bitcnt_q >= DATA_START) && (bitcnt_q[2:0] == 3'h0);
    assign live = cs_rise && !pd_q;

    // Operation kind decoded from the opcode
    always_comb begin
        case (op_q)
            OP_SECT_ERASE: new_kind = K_SECTOR;
            OP_BLK32_ERASE: new_kind = K_BLK32;
            OP_BLK64_ERASE: new_kind = K_BLK64;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: new_kind = K_CHIP;
            default: new_kind = K_PAGE;
        endcase
    end

    // Region base drops bits below the erase size
    always_comb begin
        case (new_kind)
            K_SECTOR: region = {addr_q[23:SECT_SHIFT], 12'h000};
            K_BLK32: region = {addr_q[23:BLK32_SHIFT], 15'h0000};
            K_BLK64: region = {addr_q[23:BLK64_SHIFT], 16'h0000};
            K_CHIP: region = 24'h00_0000;
            default: region = {addr_q[23:8], 8'h00};
        endcase
    end

    // Contiguous ranges: checking both ends of the region suffices
    always_comb begin
        logic [11:0] first, last;
        first = region[23:SECT_SHIFT];
        last = 12'(13'(first) + kind_sects(new_kind) - 13'h0001);
        region_prot = sect_prot(first) || sect_prot(last);
        if (new_kind == K_CHIP) begin
            region_prot = region_prot || (|block_lock_i);
        end else begin
            region_prot = region_prot || block_lock_i[region[23:16]];
        end
    end

    // both chip erase opcodes; exactly 8 bits
    assign erase_cmd = ((op_q == OP_SECT_ERASE || op_q == OP_BLK32_ERASE ||
                         op_q == OP_BLK64_ERASE) && is32) ||
                       ((op_q == OP_CHIP_ERASE_A ||
                         op_q == OP_CHIP_ERASE_B) && is8);
    assign prog_cmd = (op_q == OP_PAGE_PROG || op_q == OP_QUAD_PROG ||
                       op_q == OP_SECREG_PROG) && pp_end;

    // latch needed; idle state excludes suspend
    assign acc_erase = live && erase_cmd && wel_q &&
                       state_q == ST_IDLE && !region_prot;
    assign acc_prog = live && prog_cmd && wel_q &&
                      state_q == ST_IDLE && !region_prot;
    assign acc_susp = live && op_q == OP_SUSPEND && is8 &&
                      state_q == ST_RUN && kind_q != K_CHIP;
    assign acc_res = live && op_q == OP_RESUME && is8 && state_q == ST_SUSP;
    // power-down only on an exact 8-bit frame while not busy
    assign acc_pd = live && op_q == OP_POWER_DOWN && is8 && !pd_pend_q &&
                    state_q != ST_RUN && state_q != ST_SUSP_WAIT;
    // only the release opcode acts while powered down
    assign acc_rel = cs_rise && pd_q && op_q == OP_RELEASE &&
                     bitcnt_q >= OP_BITS;
    assign wren = live && op_q == OP_WREN && is8 &&
                  state_q != ST_RUN && state_q != ST_SUSP_WAIT;
    assign wrdi = live && op_q == OP_WRDI && is8 &&
                  state_q != ST_RUN && state_q != ST_SUSP_WAIT;

    // Next operation state; a finishing cycle beats a late suspend
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (acc_erase || acc_prog) state_d = ST_RUN;
            ST_RUN: begin
                if (tmr_if.done) begin
                    state_d = ST_IDLE;
                end else if (acc_susp) begin
                    state_d = ST_SUSP_WAIT;
                end
            end
            ST_SUSP_WAIT: begin
                if (sus_cnt_q == 32'h0000_0000) state_d = ST_SUSP;
            end
            ST_SUSP: if (acc_res) state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    assign tmr_if.load = acc_erase || acc_prog;
    assign tmr_if.load_val = kind_cyc(new_kind);
    assign tmr_if.run = (state_q == ST_RUN);

    // reset drops any suspension, so a later resume finds no target
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    // Operation record handed to the array
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            kind_q <= K_SECTOR;
            op_kind_o <= 3'h0;
            op_addr_o <= 24'h00_0000;
            op_done_o <= 1'b0;
        end else if (clk_en_i) begin
            op_done_o <= (state_q == ST_RUN) && tmr_if.done;
            if (acc_erase || acc_prog) begin
                kind_q <= new_kind;
                op_kind_o <= new_kind;
                op_addr_o <= region;
            end
        end
    end

    // busy stays up for a bounded suspend latency
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sus_cnt_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (acc_susp && !tmr_if.done) begin
                sus_cnt_q <= 32'(SUS_CYC) - 32'h0000_0001;
            end else if (sus_cnt_q != 32'h0000_0000) begin
                sus_cnt_q <= sus_cnt_q - 32'h0000_0001;
            end
        end
    end

    // flags follow the next state with no extra lag
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
            suspend_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            busy_o <= (state_d == ST_RUN) || (state_d == ST_SUSP_WAIT);
            suspend_flag_o <= (state_d == ST_SUSP_WAIT) ||
                              (state_d == ST_SUSP);
        end
    end

    // cycle end clears the latch; a same-cycle enable still wins
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wel_q <= WEL_RST;
        end else if (clk_en_i) begin
            if ((state_q == ST_RUN && tmr_if.done) || wrdi) wel_q <= 1'b0;
            if (wren) wel_q <= 1'b1;
        end
    end
    assign write_latch_flag_o = wel_q;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pd_q <= PD_RST;
            pd_pend_q <= 1'b0;
            dp_cnt_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (acc_pd) begin
                pd_pend_q <= 1'b1;
                dp_cnt_q <= 32'(DP_CYC) - 32'h0000_0001;
            end else if (pd_pend_q) begin
                if (dp_cnt_q == 32'h0000_0000) begin
                    pd_pend_q <= 1'b0;
                    pd_q <= 1'b1;
                end else begin
                    dp_cnt_q <= dp_cnt_q - 32'h0000_0001;
                end
            end else if (acc_rel) begin
                pd_q <= 1'b0;
            end
        end
    end
    assign power_down_o = pd_q;

    // status reads stay open while busy; not when powered down
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_act_q <= 1'b0;
            stat_sh_q <= 8'h00;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            if (cs_f) begin
                rd_act_q <= 1'b0;
            end else if (ck_rise && bitcnt_q == OP_BITS - 12'h001) begin
                rd_act_q <= (op_next == OP_RDSR) && !pd_q && !pd_pend_q;
            end
            // Reload each byte so a repeated read shows fresh busy state
            if (ck_rise && bitcnt_q[2:0] == 3'h7) begin
                stat_sh_q <= 8'h00;
                stat_sh_q[STAT_BUSY_BIT] <= busy_o;
                stat_sh_q[STAT_WEL_BIT] <= wel_q;
                stat_sh_q[STAT_SUS_BIT] <= suspend_flag_o;
            end else if (ck_fall && rd_act_q) begin
                miso_o <= stat_sh_q[7];
                stat_sh_q <= {stat_sh_q[6:0], 1'b0};
            end
            miso_oe_o <= rd_act_q && !cs_f;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_BUSY_NEEDS_WEL: assert property (
        $rose(busy_o) && !$past(suspend_flag_o) |-> write_latch_flag_o)
        else $error("busy rose without write latch");
    AST_PROT_REFUSED: assert property (
        $rose(busy_o) && !$past(suspend_flag_o) |->
            !block_lock_i[op_addr_o[23:16]] && !sect_prot(op_addr_o[23:12]))
        else $error("protected region accepted");
    AST_CHIP_LEN: assert property (
        $rose(busy_o) && op_kind_o == K_CHIP |-> $past(bitcnt_q) == OP_BITS)
        else $error("chip erase accepted at wrong length");
    AST_DONE_WEL: assert property (
        op_done_o && !$past(wren) |-> !write_latch_flag_o)
        else $error("latch still set after cycle end");
    AST_SUSP_FLAG: assert property (
        acc_susp && !tmr_if.done |=> suspend_flag_o && busy_o)
        else $error("suspend flag not set at once");
    AST_SUSP_LAT: assert property (
        acc_susp && !tmr_if.done |-> ##[1:sus_bound_c] !busy_o)
        else $error("busy held past suspend latency");
    AST_CHIP_NO_SUSP: assert property (
        busy_o && kind_q == K_CHIP |-> !suspend_flag_o)
        else $error("chip erase was suspended");
    AST_RES_GATE: assert property (
        acc_res |-> suspend_flag_o && !busy_o)
        else $error("resume accepted in wrong state");
    AST_RES_BUSY: assert property (
        acc_res |-> ##[1:res_bound_c] (busy_o && !suspend_flag_o))
        else $error("resume did not raise busy in time");
    AST_SUSP_REFUSE: assert property (
        suspend_flag_o |-> !(acc_erase || acc_prog))
        else $error("command accepted while suspended");
    AST_PD_ENTRY: assert property (
        acc_pd |-> ##[1:dp_bound_c] power_down_o)
        else $error("power-down not entered in time");
    AST_PD_ONLY_REL: assert property (
        power_down_o |-> !$rose(write_latch_flag_o) && !$rose(busy_o) &&
            !miso_oe_o)
        else $error("command acted while powered down");
endmodule
`default_nettype wire

// [sfe_host_model.sv]
// Host serial master model that frames commands for the sequencer
`timescale 1ns/100ps
`default_nettype none
module sfe_host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    output logic [7:0] rx_o
);
    // Select high and clock low while no frame is on the link
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        rx_o = 8'h00;
    end
    task automatic xfer(input logic [39:0] v, input int n);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_o = v[39-i];
            #200 sclk_o = 1'b1;
            rx_o = {rx_o[6:0], miso_i};
            #200 sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        // Released line flips so no stale bit survives
        mosi_o = ~mosi_o;
        #500;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Bench for erase, suspend and power-down command handling
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sfe_pkg::*;
    logic clk, rst, cs_n, sclk, mosi, miso, oe, busy, write_latch_flag, suspend_flag, pd, done;
    logic en;
    logic oe_seen;
    logic [5:0] prot;
    logic [255:0] lock;
    logic [2:0] kind;
    logic [23:0] addr;
    logic [7:0] rx;
    logic [7:0] ops [2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    int err_total = 0;
    int samples_checked = 0;
    int done_cnt = 0;
    sfe_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
        .miso_i(miso), .rx_o(rx));
    sfe_flash_seq #(.SE_CYC(200), .BE32_CYC(80), .BE64_CYC(200),
        .CE_CYC(300), .SUS_CYC(4)) dut_u (
        .ref_clk_i(clk), .reset_i(rst), .clk_en_i(en), .cs_n_i(cs_n),
        .sclk_i(sclk), .mosi_i(mosi),
        .protect_complement_bit_i(prot[5]),
        .protect_granularity_bit_i(prot[4]),
        .protect_top_bottom_bit_i(prot[3]),
        .protect_range_bit2_i(prot[2]), .protect_range_bit1_i(prot[1]),
        .protect_range_bit0_i(prot[0]), .block_lock_i(lock),
        .miso_o(miso), .miso_oe_o(oe), .busy_o(busy),
        .write_latch_flag_o(write_latch_flag), .suspend_flag_o(suspend_flag), .power_down_o(pd),
        .op_kind_o(kind), .op_addr_o(addr), .op_done_o(done));
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Catches any status drive and counts one-cycle done pulses
    always @(posedge clk) begin
        if (oe === 1'b1) oe_seen <= 1'b1;
        if (done === 1'b1) done_cnt <= done_cnt + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Frames start just after an edge so flags settle predictably
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, int n);
        @(posedge clk);
        #1;
        host_u.xfer({op, a, 8'h00}, n);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(k < 2000, 1);
        chk(write_latch_flag, 0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog sized well beyond the command sequence
    initial begin
        #3000000;
        err_total++;
        close_out();
    end
    // Main command sequence
    initial begin
        rst = 1'b1;
        en = 1'b1;
        prot = 6'h00;
        lock = '0;
        oe_seen = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge clk);
        chk(pd, 0);
        cmd(OP_BLK32_ERASE, 24'h12_3456, 32);
        chk(busy, 0);
        en = 1'b0;
        cmd(OP_WREN, 0, 8);
        en = 1'b1;
        chk(write_latch_flag, 0); // Enable low freezes the link
        cmd(OP_WREN, 0, 8);
        cmd(OP_BLK32_ERASE, 24'h12_3456, 32);
        chk({busy, kind, addr}, {1'b1, 3'h1, 24'h12_0000});
        wait_idle();
        cmd(OP_WREN, 0, 8);
        cmd(OP_BLK64_ERASE, 24'h12_3456, 24);
        cmd(OP_BLK64_ERASE, 24'h12_3456, 40);
        chk(busy, 0);
        cmd(OP_BLK64_ERASE, 24'h12_3456, 32);
        chk({busy, kind, addr}, {1'b1, 3'h2, 24'h12_0000});
        cmd(OP_RDSR, 0, 16);
        chk(rx, 8'h03);
        wait_idle();
        $display("block erase tests done");
        cmd(OP_WREN, 0, 8);
        cmd(OP_SECT_ERASE, 24'h12_3456, 32);
        chk({busy, kind, addr}, {1'b1, 3'h0, 24'h12_3000});
        cmd(OP_SUSPEND, 0, 8);
        chk({suspend_flag, busy}, 2'b10);
        cmd(OP_WREN, 0, 8);
        cmd(OP_BLK32_ERASE, 24'h01_0000, 32);
        chk({busy, kind}, {1'b0, 3'h0});
        cmd(OP_RESUME, 0, 8);
        chk({suspend_flag, busy}, 2'b01);
        wait_idle();
        cmd(OP_RESUME, 0, 8);
        cmd(OP_SUSPEND, 0, 8);
        chk({suspend_flag, busy}, 2'b00);
        cmd(OP_WREN, 0, 8);
        cmd(OP_PAGE_PROG, 24'h00_2000, 40);
        chk({busy, kind}, {1'b1, 3'h4});
        cmd(OP_SUSPEND, 0, 8);
        cmd(OP_QUAD_PROG, 24'h00_3000, 40);
        chk({suspend_flag, busy, addr}, {2'b10, 24'h00_2000});
        cmd(OP_RESUME, 0, 8);
        wait_idle();
        $display("suspend tests done");
        cmd(OP_WREN, 0, 8);
        cmd(OP_CHIP_ERASE_A, 0, 16);
        chk(busy, 0);
        cmd(OP_WRDI, 0, 8);
        cmd(OP_CHIP_ERASE_A, 0, 8);
        chk({busy, write_latch_flag}, 2'b00);
        for (int i = 0; i < 2; i++) begin
            cmd(OP_WREN, 0, 8);
            cmd(ops[i], 0, 8);
            chk({busy, kind}, {1'b1, 3'h3});
            cmd(OP_SUSPEND, 0, 8);
            chk({suspend_flag, busy}, 2'b01);
            wait_idle();
        end
        cmd(OP_WREN, 0, 8);
        lock[8'h12] = 1'b1;
        cmd(OP_BLK64_ERASE, 24'h12_0000, 32);
        chk(busy, 0);
        lock = '0;
        prot = 6'h06;
        cmd(OP_CHIP_ERASE_B, 0, 8);
        chk(busy, 0);
        prot = 6'h00;
        $display("chip erase tests done");
        cmd(OP_POWER_DOWN, 0, 9);
        chk(pd, 0);
        cmd(OP_POWER_DOWN, 0, 8);
        repeat (CYC_DP) @(posedge clk);
        #1;
        chk(pd, 1);
        oe_seen = 1'b0;
        cmd(OP_RDSR, 0, 16);
        chk(oe_seen, 0);
        cmd(OP_RELEASE, 0, 8);
        chk(pd, 0);
        cmd(OP_SECT_ERASE, 24'h00_1000, 32);
        cmd(OP_SUSPEND, 0, 8);
        chk(suspend_flag, 1);
        @(posedge clk);
        #1 rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        chk(suspend_flag, 0);
        cmd(OP_RESUME, 0, 8);
        chk({suspend_flag, busy}, 2'b00);
        chk(done_cnt, 6);
        $display("power tests done");
        close_out();
    end
endmodule
`default_nettype wire
